// [timer_channel_pkg.sv]
package timer_channel_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CONTROL     = 8'h00;
    localparam logic [7:0] OFS_CHANNEL_MODE = 8'h04;
    localparam logic [7:0] OFS_COUNTER     = 8'h10;
    localparam logic [7:0] OFS_TOP_COMPARE = 8'h1C;
    localparam logic [7:0] OFS_STATUS      = 8'h20;
    localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h24;
    localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h28;
    localparam logic [7:0] OFS_BLOCK_MODE  = 8'h30;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_TRIGGER_BIT   = 0;
    localparam int MODE_CLKSEL_LSB    = 0;
    localparam int MODE_INVERT_BIT    = 3;
    localparam int MODE_BURST_LSB     = 4;
    localparam int MODE_STOP_TOP_BIT  = 6;
    localparam int MODE_WAVE_BIT      = 15;
    localparam int STAT_OVERFLOW_BIT  = 0;
    localparam int STAT_TOP_HIT_BIT   = 1;
    localparam int STAT_STOPPED_BIT   = 16;
    localparam int NUM_EVENTS         = 2;
    localparam int NUM_EXT_LINES      = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] RST_CHANNEL_MODE = 32'h0000_0000;
    localparam logic [15:0] RST_TOP_COMPARE  = 16'h0000;
    localparam logic [15:0] RST_COUNTER      = 16'h0000;
    localparam logic [15:0] COUNTER_ALL_ONES = 16'hFFFF;

    // ****************************************
    // Prescaler taps: divide by 2, 8, 32, 128, 1024
    // ****************************************
    localparam int PRESCALE_WIDTH = 10;
    localparam int TAP_DIV2    = 0;
    localparam int TAP_DIV8    = 2;
    localparam int TAP_DIV32   = 4;
    localparam int TAP_DIV128  = 6;
    localparam int TAP_DIV1024 = 9;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : timer_channel_pkg

// [sync_2ff.sv]
`timescale 1ns/1ns
// ****************************************
// Two-stage synchroniser for pin levels
// ****************************************
module sync_2ff #(
    parameter int WIDTH = 3
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule : sync_2ff

// [timer_prescaler.sv]
`timescale 1ns/1ns
// ****************************************
// Free-running divider of the system clock
// ****************************************
module timer_prescaler #(
    parameter int WIDTH = timer_channel_pkg::PRESCALE_WIDTH
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    output logic      [4:0] div_level
);

    logic [WIDTH-1:0] presc_r;
    logic [WIDTH-1:0] presc_nxt;

    assign presc_nxt = presc_r + {{(WIDTH-1){1'b0}}, 1'b1};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            presc_r <= '0;
        else
            presc_r <= presc_nxt;
    end

    // Each tap is a square wave; its rising edge marks one divided tick
    assign div_level = {presc_r[timer_channel_pkg::TAP_DIV1024],
                        presc_r[timer_channel_pkg::TAP_DIV128],
                        presc_r[timer_channel_pkg::TAP_DIV32],
                        presc_r[timer_channel_pkg::TAP_DIV8],
                        presc_r[timer_channel_pkg::TAP_DIV2]};

endmodule : timer_prescaler

// [timer_counter_channel.sv]
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module timer_counter_channel (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  ext_clock_pin,
    input  wire logic [2:0]  channel_io_line_a,
    output logic             irq
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : strb_mask

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        merge = (old_v & ~strb_mask(strb)) | (new_v & strb_mask(strb));
    endfunction : merge

    // ****************************************
    // Bus slave state
    // ****************************************
    logic        aw_held_r;
    logic [7:0]  awaddr_r;
    logic        w_held_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    // ****************************************
    // Registers and counter state
    // ****************************************
    logic [31:0] chan_mode_r;
    logic [15:0] top_r;
    logic [2:0]  block_mode_r;
    localparam int NUM_EV = timer_channel_pkg::NUM_EVENTS;
    logic [NUM_EV-1:0] status_r;
    logic [NUM_EV-1:0] irq_en_r;
    logic [15:0] cnt_r;
    logic        trig_pend_r;
    logic        clk_stop_r;
    logic        gated_prev_r;

    // ****************************************
    // Write decode
    // ****************************************
    logic do_write;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_top;
    logic wr_en;
    logic wr_clr;
    logic wr_block;
    logic wr_known;
    logic sw_trig;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign wr_ctrl  = do_write && awaddr_r == timer_channel_pkg::OFS_CONTROL;
    assign wr_mode  = do_write && awaddr_r == timer_channel_pkg::OFS_CHANNEL_MODE;
    assign wr_top   = do_write && awaddr_r == timer_channel_pkg::OFS_TOP_COMPARE;
    assign wr_en    = do_write && awaddr_r == timer_channel_pkg::OFS_IRQ_ENABLE;
    assign wr_clr   = do_write && awaddr_r == timer_channel_pkg::OFS_IRQ_CLEAR;
    assign wr_block = do_write && awaddr_r == timer_channel_pkg::OFS_BLOCK_MODE;
    assign wr_known = wr_ctrl || wr_mode || wr_top || wr_en || wr_clr || wr_block;
    assign sw_trig  = wr_ctrl && wstrb_r[0] && wdata_r[timer_channel_pkg::CTRL_TRIGGER_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            awaddr_r  <= 8'h00;
            w_held_r  <= 1'b0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= timer_channel_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_known ? timer_channel_pkg::RESP_OKAY
                                      : timer_channel_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ****************************************
    // Clock selection
    // ****************************************
    logic [4:0] div_level;
    logic [2:0] pin_sync;
    logic [2:0] chain_sync;
    logic [2:0] ext_line;
    logic [2:0] clk_sel;
    logic [1:0] burst_sel;
    logic       invert;
    logic       stop_top;
    logic       wave;
    logic       sel_level;
    logic       burst_ok;
    logic       gated_level;
    logic       raw_edge;
    logic       valid_edge;

    timer_prescaler u_prescaler (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .div_level (div_level)
    );

    sync_2ff #(.WIDTH(3)) u_sync_pin (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (ext_clock_pin),
        .sync_out (pin_sync)
    );

    sync_2ff #(.WIDTH(3)) u_sync_chain (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (channel_io_line_a),
        .sync_out (chain_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < timer_channel_pkg::NUM_EXT_LINES; gi++)
        begin : g_ext
            assign ext_line[gi] = block_mode_r[gi] ? chain_sync[gi] : pin_sync[gi];
        end
    endgenerate

    assign clk_sel   = chan_mode_r[timer_channel_pkg::MODE_CLKSEL_LSB +: 3];
    assign burst_sel = chan_mode_r[timer_channel_pkg::MODE_BURST_LSB +: 2];
    assign invert    = chan_mode_r[timer_channel_pkg::MODE_INVERT_BIT];
    assign stop_top  = chan_mode_r[timer_channel_pkg::MODE_STOP_TOP_BIT];
    assign wave      = chan_mode_r[timer_channel_pkg::MODE_WAVE_BIT];

    // Codes 5..7 pick the external lines, 0..4 the divider taps
    assign sel_level = clk_sel[2] && clk_sel != 3'd4 ? ext_line[clk_sel[1:0] - 2'd1]
                                                     : div_level[clk_sel];
    assign burst_ok    = burst_sel == 2'd0 ? 1'b1 : ext_line[burst_sel - 2'd1];
    assign gated_level = sel_level && burst_ok;
    assign raw_edge    = invert ? (!gated_level && gated_prev_r)
                                : (gated_level && !gated_prev_r);
    assign valid_edge  = raw_edge && !clk_stop_r;

    // ****************************************
    // Counter
    // ****************************************
    logic [15:0] cnt_inc;
    logic [15:0] cnt_nxt;
    logic        ovf_ev;
    logic        top_ev;
    logic        stop_nxt;

    assign cnt_inc = cnt_r + 16'h0001;
    assign cnt_nxt = !valid_edge ? cnt_r
                   : trig_pend_r ? timer_channel_pkg::RST_COUNTER
                   : cnt_inc;
    assign ovf_ev  = valid_edge && !trig_pend_r
                     && cnt_r == timer_channel_pkg::COUNTER_ALL_ONES;
    assign top_ev  = valid_edge && cnt_nxt == top_r;
    // A trigger releases a stopped clock so the zero load can happen
    assign stop_nxt = sw_trig ? 1'b0
                    : (clk_stop_r || (wave && stop_top && top_ev));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r        <= timer_channel_pkg::RST_COUNTER;
            trig_pend_r  <= 1'b0;
            clk_stop_r   <= 1'b0;
            gated_prev_r <= 1'b0;
        end
        else
        begin
            cnt_r        <= cnt_nxt;
            trig_pend_r  <= sw_trig || (trig_pend_r && !valid_edge);
            clk_stop_r   <= stop_nxt;
            gated_prev_r <= gated_level;
        end
    end

    // ****************************************
    // Software registers and events
    // ****************************************
    logic [NUM_EV-1:0] ev_set;
    logic [NUM_EV-1:0] ev_clr;

    assign ev_set = {top_ev, ovf_ev};
    logic [31:0] clr_word;
    logic [31:0] top_word;
    logic [31:0] blk_word;
    logic [31:0] ien_word;

    assign clr_word = merge(32'h0000_0000, wdata_r, wstrb_r);
    assign top_word = merge({16'h0000, top_r}, wdata_r, wstrb_r);
    assign blk_word = merge({29'h0, block_mode_r}, wdata_r, wstrb_r);
    assign ien_word = merge({{(32-NUM_EV){1'b0}}, irq_en_r}, wdata_r, wstrb_r);
    assign ev_clr   = wr_clr ? clr_word[NUM_EV-1:0] : '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            chan_mode_r  <= timer_channel_pkg::RST_CHANNEL_MODE;
            top_r        <= timer_channel_pkg::RST_TOP_COMPARE;
            block_mode_r <= 3'b000;
            status_r     <= '0;
            irq_en_r     <= '0;
        end
        else
        begin
            if (wr_mode)
                chan_mode_r <= merge(chan_mode_r, wdata_r, wstrb_r);
            if (wr_top)
                top_r <= top_word[15:0];
            if (wr_block)
                block_mode_r <= blk_word[2:0];
            if (wr_en)
                irq_en_r <= ien_word[NUM_EV-1:0];
            // Set wins over a clear in the same cycle
            status_r <= (status_r & ~ev_clr) | ev_set;
        end
    end

    assign irq = |(status_r & irq_en_r);

    // ****************************************
    // Read path
    // ****************************************
    logic [31:0] rd_mux;
    logic        rd_known;
    logic [31:0] status_word;

    assign status_word = {15'h0, clk_stop_r, 14'h0, status_r};
    assign rd_known = s_axi_araddr == timer_channel_pkg::OFS_CONTROL
                   || s_axi_araddr == timer_channel_pkg::OFS_CHANNEL_MODE
                   || s_axi_araddr == timer_channel_pkg::OFS_COUNTER
                   || s_axi_araddr == timer_channel_pkg::OFS_TOP_COMPARE
                   || s_axi_araddr == timer_channel_pkg::OFS_STATUS
                   || s_axi_araddr == timer_channel_pkg::OFS_IRQ_ENABLE
                   || s_axi_araddr == timer_channel_pkg::OFS_IRQ_CLEAR
                   || s_axi_araddr == timer_channel_pkg::OFS_BLOCK_MODE;
    assign rd_mux =
        s_axi_araddr == timer_channel_pkg::OFS_CHANNEL_MODE ? chan_mode_r
      : s_axi_araddr == timer_channel_pkg::OFS_COUNTER ? {16'h0000, cnt_r}
      : s_axi_araddr == timer_channel_pkg::OFS_TOP_COMPARE ? {16'h0000, top_r}
      : s_axi_araddr == timer_channel_pkg::OFS_STATUS ? status_word
      : s_axi_araddr == timer_channel_pkg::OFS_IRQ_ENABLE ? {30'h0, irq_en_r}
      : s_axi_araddr == timer_channel_pkg::OFS_BLOCK_MODE ? {29'h0, block_mode_r}
      : 32'h0000_0000;

    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= timer_channel_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_known ? timer_channel_pkg::RESP_OKAY
                                 : timer_channel_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_COUNT_STEP: assert property (
        valid_edge && !trig_pend_r |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
        else $error("Counter did not advance by one");
    AST_COUNT_HOLD: assert property (
        !valid_edge |=> $stable(cnt_r))
        else $error("Counter moved without a valid edge");
    AST_OVERFLOW: assert property (
        valid_edge && !trig_pend_r && cnt_r == 16'hFFFF |=> cnt_r == 16'h0000 && status_r[0])
        else $error("Wrap did not set overflow");
    AST_TRIG_LOAD: assert property (
        sw_trig ##1 (!valid_edge) [*2] |=> cnt_r == $past(cnt_r, 2) && trig_pend_r)
        else $error("Trigger cleared counter before an edge");
    AST_TRIG_ZERO: assert property (
        trig_pend_r && valid_edge |=> cnt_r == 16'h0000 && !trig_pend_r)
        else $error("Trigger did not load zero on edge");
    AST_STOPPED: assert property (
        clk_stop_r |-> !valid_edge)
        else $error("Counted while clock stopped");
    AST_STOP_SET: assert property (
        wave && stop_top && top_ev && !sw_trig |=> clk_stop_r)
        else $error("Clock not stopped at top compare");
    AST_EDGE_POL: assert property (
        valid_edge |-> gated_level == !invert && gated_prev_r == invert)
        else $error("Counted on the wrong edge");
    AST_BURST_GATE: assert property (
        valid_edge && !invert && burst_sel != 2'd0 |-> ext_line[burst_sel - 2'd1])
        else $error("Counted while burst line low");
    AST_IRQ_LEVEL: assert property (
        ovf_ev && irq_en_r[0] |=> irq ##1 (irq || $past(wr_clr || wr_en)))
        else $error("Interrupt missing after enabled event");

    COV_OVERFLOW: cover property (ovf_ev);
    COV_TRIGGER:  cover property (trig_pend_r && valid_edge);
    COV_STOP:     cover property ($rose(clk_stop_r));
    COV_BURST:    cover property (valid_edge && burst_sel != 2'd0);

endmodule : timer_counter_channel

// [timer_ext_source.sv]
`timescale 1ns/1ns
// ****************************************
// Far side: clock pins and chained lines
// ****************************************
module timer_ext_source (
    input  wire logic       aclk,
    output logic      [2:0] ext_clock_pin,
    output logic      [2:0] channel_io_line_a
);
    initial
    begin
        ext_clock_pin     = 3'b000;
        channel_io_line_a = 3'b000;
    end

    task automatic set_line(input int idx, input bit io, input logic lvl);
        @(posedge aclk);
        if (io)
            channel_io_line_a[idx] <= lvl;
        else
            ext_clock_pin[idx] <= lvl;
    endtask : set_line

    // Each level lasts three system clocks, a sixth of its rate
    task automatic pulses(input int idx, input bit io, input int n);
        repeat (n)
        begin
            set_line(idx, io, 1'b1);
            repeat (2) @(posedge aclk);
            set_line(idx, io, 1'b0);
            repeat (2) @(posedge aclk);
        end
    endtask : pulses
endmodule : timer_ext_source

// [timer_counter_channel_tb.sv]
`timescale 1ns/1ns
module timer_counter_channel_tb;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [7:0] A_CTL = timer_channel_pkg::OFS_CONTROL;
    localparam logic [7:0] A_MOD = timer_channel_pkg::OFS_CHANNEL_MODE;
    localparam logic [7:0] A_CNT = timer_channel_pkg::OFS_COUNTER;
    localparam logic [7:0] A_TOP = timer_channel_pkg::OFS_TOP_COMPARE;
    localparam logic [7:0] A_STA = timer_channel_pkg::OFS_STATUS;
    localparam logic [7:0] A_IEN = timer_channel_pkg::OFS_IRQ_ENABLE;
    localparam logic [7:0] A_ICL = timer_channel_pkg::OFS_IRQ_CLEAR;
    localparam logic [7:0] A_BLK = timer_channel_pkg::OFS_BLOCK_MODE;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic [2:0]  ext_clock_pin;
    logic [2:0]  channel_io_line_a;
    logic        irq;
    int          err_total;
    int          total_checks;
    logic [1:0]  bresp_q;
    logic [1:0]  rresp_q;
    logic [31:0] a;
    logic [31:0] b;
    logic [15:0] d;
    int          div_tab [5] = '{2, 8, 32, 128, 1024};

    timer_counter_channel uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ext_clock_pin(ext_clock_pin),
        .channel_io_line_a(channel_io_line_a), .irq(irq));

    timer_ext_source src (.aclk(aclk), .ext_clock_pin(ext_clock_pin),
        .channel_io_line_a(channel_io_line_a));

    initial aclk = 1'b0;
    always #50 aclk = ~aclk;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        logic aw_ok;
        logic w_ok;
        logic ta;
        logic tw;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && (s_axi_awready === 1'b1);
            tw = s_axi_wvalid && (s_axi_wready === 1'b1);
            @(posedge aclk);
            if (ta)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (tw)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        @(negedge aclk);
        while (s_axi_bvalid !== 1'b1) @(negedge aclk);
        bresp_q = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        @(negedge aclk);
        while (s_axi_arready !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(negedge aclk);
        while (s_axi_rvalid !== 1'b1) @(negedge aclk);
        dt = s_axi_rdata;
        rresp_q = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic idle(input int k);
        repeat (k) @(posedge aclk);
    endtask : idle

    // Counter change across a run of pulses on one line
    task automatic ext_run(input int idx, input bit io, input int n, output logic [15:0] dv);
        logic [31:0] x;
        logic [31:0] y;
        rd(A_CNT, x);
        src.pulses(idx, io, n);
        idle(6);
        rd(A_CNT, y);
        dv = y[15:0] - x[15:0];
    endtask : ext_run

    function automatic logic [31:0] mode(input logic [2:0] cs, input logic inv,
                                         input logic [1:0] bur, input logic stp);
        mode = 32'h0000_8000;
        mode[2:0] = cs;
        mode[timer_channel_pkg::MODE_INVERT_BIT] = inv;
        mode[5:4] = bur;
        mode[timer_channel_pkg::MODE_STOP_TOP_BIT] = stp;
    endfunction : mode

    task automatic results;
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    initial
    begin
        #4_000_000;
        err_total++;
        results();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        err_total = 0;
        total_checks = 0;
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(A_MOD, a);
        check("mode_reset", a, timer_channel_pkg::RST_CHANNEL_MODE);
        rd(A_STA, a);
        check("status_reset", a, 32'h0000_0000);
        rd(8'h08, a);
        check("unmapped_rdata", a, 32'h0000_0000);
        check("unmapped_rresp", {30'h0, rresp_q}, {30'h0, timer_channel_pkg::RESP_SLVERR});
        wr(8'h0C, 32'h0000_0001);
        check("unmapped_bresp", {30'h0, bresp_q}, {30'h0, timer_channel_pkg::RESP_SLVERR});
        wr(A_MOD, 32'h5A5A_0000);
        rd(A_MOD, a);
        check("mode_rw", a, 32'h5A5A_0000);
        for (int i = 0; i < 5; i++)
        begin
            wr(A_MOD, mode(i, 1'b0, 2'b00, 1'b0));
            rd(A_CNT, a);
            idle(div_tab[i] * 4);
            rd(A_CNT, b);
            d = b[15:0] - a[15:0];
            check("div_rate", {31'h0, (d >= 16'h0004 && d <= 16'h0006)}, 32'h0000_0001);
        end
        for (int n = 0; n < 3; n++)
        begin
            wr(A_BLK, 32'h0000_0000);
            wr(A_MOD, mode(3'd5 + n, 1'b0, 2'b00, 1'b0));
            ext_run(n, 1'b0, 5, d);
            check("ext_pin", {16'h0, d}, 32'h0000_0005);
            ext_run(n, 1'b1, 2, d);
            check("chain_unused", {16'h0, d}, 32'h0000_0000);
            wr(A_BLK, 32'h0000_0001 << n);
            ext_run(n, 1'b1, 3, d);
            check("chain_used", {16'h0, d}, 32'h0000_0003);
            ext_run(n, 1'b0, 2, d);
            check("pin_unused", {16'h0, d}, 32'h0000_0000);
        end
        wr(A_BLK, 32'h0000_0000);
        for (int v = 0; v < 2; v++)
        begin
            wr(A_MOD, mode(3'd5, v[0], 2'b00, 1'b0));
            rd(A_CNT, a);
            src.set_line(0, 1'b0, 1'b1);
            idle(6);
            rd(A_CNT, b);
            check("rise_edge", {16'h0, b[15:0] - a[15:0]}, {31'h0, ~v[0]});
            src.set_line(0, 1'b0, 1'b0);
            idle(6);
            rd(A_CNT, a);
            check("fall_edge", {16'h0, a[15:0] - b[15:0]}, {31'h0, v[0]});
        end
        wr(A_MOD, mode(3'd5, 1'b0, 2'b10, 1'b0));
        ext_run(0, 1'b0, 4, d);
        check("burst_low", {16'h0, d}, 32'h0000_0000);
        src.set_line(1, 1'b0, 1'b1);
        ext_run(0, 1'b0, 4, d);
        check("burst_high", {16'h0, d}, 32'h0000_0004);
        src.set_line(1, 1'b0, 1'b0);
        wr(A_MOD, mode(3'd5, 1'b0, 2'b00, 1'b0));
        rd(A_CNT, a);
        wr(A_CTL, 32'h0000_0001);
        rd(A_CNT, b);
        check("trig_wait", b, a);
        ext_run(0, 1'b0, 1, d);
        rd(A_CNT, a);
        check("trig_load", a, 32'h0000_0000);
        wr(A_TOP, 32'h0000_0003);
        wr(A_IEN, 32'h0000_0002);
        wr(A_MOD, mode(3'd5, 1'b0, 2'b00, 1'b1));
        wr(A_CTL, 32'h0000_0001);
        ext_run(0, 1'b0, 1, d);
        wr(A_ICL, 32'h0000_0003);
        check("irq_idle", {31'h0, irq}, 32'h0000_0000);
        ext_run(0, 1'b0, 6, d);
        rd(A_CNT, a);
        check("stop_count", a, 32'h0000_0003);
        rd(A_STA, a);
        check("stop_status", a, 32'h0001_0002);
        check("irq_set", {31'h0, irq}, 32'h0000_0001);
        wr(A_IEN, 32'h0000_0000);
        check("irq_mask", {31'h0, irq}, 32'h0000_0000);
        wr(A_IEN, 32'h0000_0002);
        check("irq_unmask", {31'h0, irq}, 32'h0000_0001);
        wr(A_ICL, 32'h0000_0002);
        check("irq_clear", {31'h0, irq}, 32'h0000_0000);
        rd(A_STA, a);
        check("status_clear", a, 32'h0001_0000);
        wr(A_MOD, mode(3'd5, 1'b0, 2'b00, 1'b0));
        wr(A_CTL, 32'h0000_0001);
        ext_run(0, 1'b0, 1, d);
        ext_run(0, 1'b0, 6, d);
        rd(A_CNT, a);
        check("no_stop", a, 32'h0000_0006);
        results();
    end
endmodule : timer_counter_channel_tb
